// >>> logic/meas_seq_pkg.sv
// Shared types and constants for the measurement cycle sequencer
package meas_seq_pkg;

  localparam int unsigned STARTUP_CONVERSIONS = 5;
  localparam int unsigned NORMAL_CONVERSIONS  = 12;
  localparam logic [3:0]  STARTUP_LAST        = 4'h4;
  localparam logic [3:0]  NORMAL_LAST         = 4'hB;
  localparam logic [3:0]  SLOT_RESET          = 4'h0;

  // Signed step count limits for extended offset compensation
  localparam logic signed [5:0] STEP_MAX = 6'sh1F;
  localparam logic signed [5:0] STEP_MIN = -6'sh1F;

  // Offset shift per step in thousandths of a percent of span
  localparam logic [10:0] STEP_SHIFT_125 = 11'h4E2;
  localparam logic [10:0] STEP_SHIFT_076 = 11'h2F8;
  localparam logic [10:0] STEP_SHIFT_052 = 11'h208;
  localparam logic [10:0] STEP_SHIFT_008 = 11'h053;

  // Gain selection codes, highest gain first
  localparam logic [3:0] GAIN_420  = 4'h0;
  localparam logic [3:0] GAIN_280  = 4'h1;
  localparam logic [3:0] GAIN_210  = 4'h2;
  localparam logic [3:0] GAIN_140  = 4'h3;
  localparam logic [3:0] GAIN_105  = 4'h4;
  localparam logic [3:0] GAIN_70   = 4'h5;
  localparam logic [3:0] GAIN_52   = 4'h6;
  localparam logic [3:0] GAIN_35   = 4'h7;
  localparam logic [3:0] GAIN_26   = 4'h8;
  localparam logic [3:0] GAIN_14   = 4'h9;
  localparam logic [3:0] GAIN_9    = 4'hA;
  localparam logic [3:0] GAIN_7    = 4'hB;
  localparam logic [3:0] GAIN_2P8  = 4'hC;

  typedef enum logic [6:0] {
    bridge_signal_conversion     = 7'h01,
    temp_autozero_conversion     = 7'h02,
    temp_calibration_conversion  = 7'h04,
    common_mode_check_conversion = 7'h08,
    positive_short_check         = 7'h10,
    negative_short_check         = 7'h20,
    bridge_autozero_conversion   = 7'h40
  } conv_kind_t;

  typedef enum logic [2:0] {
    src_bridge = 3'h1,
    src_temp   = 3'h2,
    src_offset = 3'h4
  } mux_source_t;

  typedef enum logic [2:0] {
    st_idle  = 3'h1,
    st_issue = 3'h2,
    st_wait  = 3'h4
  } seq_state_t;

  typedef struct packed {
    logic              valid;
    logic              safety_en;
    logic [3:0]        gain_code;
    logic signed [5:0] extended_offset_comp_steps;
  } seq_cfg_t;

  typedef struct packed {
    conv_kind_t  kind;
    mux_source_t source;
  } conv_req_t;

endpackage

// >>> logic/measurement_cycle_sequencer.sv
// Measurement cycle sequencer steering the converter input multiplexer
`timescale 1ns/10ps
module measurement_cycle_sequencer
  import meas_seq_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Configuration memory
  input  wire seq_cfg_t           cfg,
  // Converter handshake
  output logic                    conv_start,
  input  wire logic               conv_done,
  output conv_req_t               conv_req_r,
  // Status
  output logic                    normal_mode_r,
  output logic [3:0]              slot_r,
  output logic signed [5:0]       comp_steps_r,
  output logic signed [17:0]      comp_shift_r
);

  seq_state_t state_r;
  seq_state_t state_nxt;
  logic [3:0] slot_nxt;
  logic       normal_mode_nxt;
  conv_req_t  conv_req_nxt;
  logic       last_slot;

  function automatic conv_kind_t slot_kind(input logic       normal,
                                           input logic [3:0] slot,
                                           input logic       safety);
    conv_kind_t k;
    k = bridge_signal_conversion;
    if (!normal)
    begin
      case (slot)
        4'h0:    k = temp_autozero_conversion;
        4'h1:    k = temp_calibration_conversion;
        4'h2:    k = bridge_autozero_conversion;
        default: k = bridge_signal_conversion;
      endcase
    end
    else if (slot[0])
    begin
      case (slot)
        4'h1:    k = temp_autozero_conversion;
        4'h3:    k = temp_calibration_conversion;
        4'h5:    k = safety ? common_mode_check_conversion
                            : temp_calibration_conversion;
        4'h7:    k = safety ? positive_short_check
                            : temp_calibration_conversion;
        4'h9:    k = safety ? negative_short_check
                            : temp_calibration_conversion;
        default: k = bridge_autozero_conversion;
      endcase
    end
    return k;
  endfunction

  function automatic mux_source_t kind_source(input conv_kind_t k);
    mux_source_t s;
    case (k)
      temp_calibration_conversion:  s = src_temp;
      temp_autozero_conversion,
      bridge_autozero_conversion:   s = src_offset;
      default:                      s = src_bridge;
    endcase
    return s;
  endfunction

  assign conv_start = (state_r == st_issue);
  assign last_slot  = normal_mode_r ? (slot_r == NORMAL_LAST)
                                    : (slot_r == STARTUP_LAST);

  always_comb
  begin
    state_nxt       = state_r;
    slot_nxt        = slot_r;
    normal_mode_nxt = normal_mode_r;
    conv_req_nxt    = conv_req_r;
    case (state_r)
      st_idle:
      begin
        // Hold off until configuration memory has been read out
        if (cfg.valid)
          state_nxt = st_issue;
      end
      st_issue:
        state_nxt = st_wait;
      st_wait:
      begin
        if (conv_done)
        begin
          state_nxt = st_issue;
          if (last_slot)
          begin
            slot_nxt        = SLOT_RESET;
            normal_mode_nxt = 1'b1;
          end
          else
            slot_nxt = slot_r + 4'h1;
        end
      end
      default:
        state_nxt = st_idle;
    endcase
    // Request moves only at a hand-over, never while a conversion runs
    if ((state_r == st_idle) || ((state_r == st_wait) && conv_done))
    begin
      conv_req_nxt.kind   = slot_kind(normal_mode_nxt, slot_nxt,
                                      cfg.safety_en);
      conv_req_nxt.source = kind_source(conv_req_nxt.kind);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r         <= st_idle;
      slot_r          <= SLOT_RESET;
      normal_mode_r   <= 1'b0;
      conv_req_r      <= '{temp_autozero_conversion, src_offset};
    end
    else
    begin
      state_r         <= state_nxt;
      slot_r          <= slot_nxt;
      normal_mode_r   <= normal_mode_nxt;
      conv_req_r      <= conv_req_nxt;
    end
  end

  offset_comp_scale u_offset_comp (
    .clk       (clk),
    .rst_n     (rst_n),
    .gain_code (cfg.gain_code),
    .steps_in  (cfg.extended_offset_comp_steps),
    .steps_r   (comp_steps_r),
    .shift_r   (comp_shift_r)
  );

  // Kind of the previous started conversion, for the alternation check
  conv_kind_t prev_kind_r;
  conv_kind_t prev_kind_nxt;

  always_comb
  begin
    prev_kind_nxt = prev_kind_r;
    if (conv_start)
      prev_kind_nxt = conv_req_r.kind;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      prev_kind_r <= bridge_autozero_conversion;
    else
      prev_kind_r <= prev_kind_nxt;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_start_single_pulse : assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  a_req_stable_wait : assert property (state_r == st_wait && !conv_done
    |=> $stable(conv_req_r))
    else $error("request changed during conversion");
  a_source_matches_kind : assert property (conv_start |->
    $onehot(conv_req_r.source) &&
    ((conv_req_r.source == src_temp) ==
     (conv_req_r.kind == temp_calibration_conversion)) &&
    ((conv_req_r.source == src_offset) ==
     (conv_req_r.kind inside {temp_autozero_conversion,
                              bridge_autozero_conversion})))
    else $error("multiplexer source does not match kind");
  a_startup_slot_bound : assert property (!normal_mode_r |->
    slot_r <= STARTUP_LAST)
    else $error("startup slot out of range");
  a_normal_stays_on : assert property (normal_mode_r |=>
    normal_mode_r)
    else $error("normal cycle left");
  a_bridge_before_special : assert property (conv_start && normal_mode_r &&
    conv_req_r.kind != bridge_signal_conversion
    |-> prev_kind_r == bridge_signal_conversion)
    else $error("special conversion without bridge before it");
  a_startup_five_conv : assert property ($rose(normal_mode_r) |->
    $past(slot_r) == STARTUP_LAST && $past(conv_done))
    else $error("startup did not last five conversions");
  a_cycle_wraps_twelve : assert property (normal_mode_r && state_r == st_wait
    && conv_done && slot_r == NORMAL_LAST
    |=> slot_r == SLOT_RESET && conv_start &&
        conv_req_r.kind == bridge_signal_conversion)
    else $error("normal cycle did not wrap after twelve");
  a_even_slot_bridge : assert property (conv_start && normal_mode_r &&
    !slot_r[0] |-> conv_req_r.kind == bridge_signal_conversion)
    else $error("even slot of the cycle is not a bridge conversion");
  a_start_after_done : assert property (state_r == st_wait && conv_done
    |=> conv_start)
    else $error("no start right after a finished conversion");
  a_normal_slot_bound : assert property (normal_mode_r |->
    slot_r <= NORMAL_LAST)
    else $error("cycle slot out of range");
  a_wait_holds_slot : assert property (state_r == st_wait && !conv_done
    |=> $stable(slot_r) && $stable(normal_mode_r))
    else $error("slot moved during a conversion");
  a_safety_off_kinds : assert property (conv_start && normal_mode_r &&
    !$past(cfg.safety_en) |-> !(conv_req_r.kind inside
    {common_mode_check_conversion, positive_short_check,
     negative_short_check}))
    else $error("safety check started while disabled");

  c_startup_done   : cover property ($rose(normal_mode_r));
  c_cycle_wrap     : cover property (normal_mode_r && slot_r == NORMAL_LAST
    && conv_done);
  c_short_check    : cover property (conv_start &&
    conv_req_r.kind == negative_short_check);
  c_safety_off     : cover property (conv_start && normal_mode_r &&
    slot_r == 4'h5 && conv_req_r.kind == temp_calibration_conversion);
  c_fast_handover  : cover property (conv_start ##2 conv_start);

endmodule

// >>> logic/xzc_offset_scale.sv
// Extended offset compensation: clamps step count, scales by gain
`timescale 1ns/10ps
module offset_comp_scale
  import meas_seq_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Configuration
  input  wire logic [3:0]         gain_code,
  input  wire logic signed [5:0]  steps_in,
  // Results
  output logic signed [5:0]       steps_r,
  output logic signed [17:0]      shift_r
);

  logic [10:0]        unit;
  logic signed [5:0]  steps_nxt;
  logic signed [17:0] shift_nxt;

  always_comb
  begin
    case (gain_code)
      GAIN_420, GAIN_210, GAIN_105, GAIN_52, GAIN_14: unit = STEP_SHIFT_125;
      GAIN_280, GAIN_140, GAIN_70, GAIN_35, GAIN_9:   unit = STEP_SHIFT_076;
      GAIN_26, GAIN_7:                                unit = STEP_SHIFT_052;
      default:                                        unit = STEP_SHIFT_008;
    endcase
    // Code -32 has no meaning; pin it to the last legal step
    steps_nxt = (steps_in < STEP_MIN) ? STEP_MIN : steps_in;
    // Widen both factors first so the product keeps all its bits
    shift_nxt = 18'(steps_nxt) * 18'($signed({1'b0, unit}));
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      steps_r <= 6'sh00;
      shift_r <= 18'sh00000;
    end
    else
    begin
      steps_r <= steps_nxt;
      shift_r <= shift_nxt;
    end
  end

  a_comp_step_range : assert property (@(posedge clk) disable iff (!rst_n)
    (steps_r >= STEP_MIN) && (steps_r <= STEP_MAX))
    else $error("offset step count out of range");

endmodule

// >>> sim/adc_partner_model.sv
// Converter model answering each start with a done pulse after lat cycles
`timescale 1ns/10ps
module adc_partner_model
(
  // Clock
  input  wire logic clk,
  // Handshake
  input  wire logic conv_start,
  output logic      conv_done,
  // Latency in cycles, at least 1
  input  wire logic [31:0] lat
);
  initial
  begin
    conv_done = 1'b0;
    forever
    begin
      // Sampled mid-cycle to stay clear of the start edge
      @(negedge clk);
      if (conv_start === 1'b1)
      begin
        repeat (lat) @(posedge clk);
        #1 conv_done = 1'b1;
        @(posedge clk);
        #1 conv_done = 1'b0;
      end
    end
  end
endmodule

// >>> sim/tb_measurement_cycle_sequencer.sv
// Self-checking bench for the measurement cycle sequencer
`timescale 1ns/10ps
module tb_measurement_cycle_sequencer;
  import meas_seq_pkg::*;
  logic              clk;
  logic              rst_n;
  seq_cfg_t          cfg;
  logic              conv_start;
  logic              conv_done;
  conv_req_t         conv_req_r;
  logic              normal_mode_r;
  logic [3:0]        slot_r;
  logic signed [5:0] comp_steps_r;
  logic signed [17:0] comp_shift_r;
  int                lat;
  int                num_errors;
  int                n_compared;
  conv_kind_t        kinds [17];

  measurement_cycle_sequencer i_measurement_cycle_sequencer (
    .clk(clk), .rst_n(rst_n), .cfg(cfg), .conv_start(conv_start),
    .conv_done(conv_done), .conv_req_r(conv_req_r),
    .normal_mode_r(normal_mode_r), .slot_r(slot_r),
    .comp_steps_r(comp_steps_r), .comp_shift_r(comp_shift_r));
  adc_partner_model i_adc_partner_model (
    .clk(clk), .conv_start(conv_start), .conv_done(conv_done), .lat(lat));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(string what, logic [17:0] exp, logic [17:0] got);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  function automatic mux_source_t src_of(conv_kind_t k);
    if (k == temp_autozero_conversion || k == bridge_autozero_conversion)
      return src_offset;
    if (k == temp_calibration_conversion)
      return src_temp;
    return src_bridge;
  endfunction

  task automatic do_reset(seq_cfg_t c);
    @(posedge clk);
    #1 cfg = c;
    rst_n = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check("start", 1'b0, conv_start);
    check("req", {temp_autozero_conversion, src_offset}, conv_req_r);
    check("mode", 1'b0, normal_mode_r);
    check("slot", 4'h0, slot_r);
    rst_n = 1'b1;
  endtask

  task automatic wait_start();
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (conv_start !== 1'b1 && n < 200);
    if (conv_start !== 1'b1)
    begin
      num_errors++;
      $display("Error conv_start expected 1 seen %b", conv_start);
      tally_and_finish();
    end
  endtask

  // Index 0..4 startup, then normal slots repeating
  task automatic run_seq(logic safety, int n);
    conv_kind_t k;
    int s;
    for (int i = 0; i < n; i++)
    begin
      s = (i < 5) ? i : (i - 5) % 12;
      k = kinds[(i < 5) ? i : 5 + s];
      if (!safety && i >= 5 && (s == 5 || s == 7 || s == 9))
        k = temp_calibration_conversion;
      wait_start();
      check("kind", k, conv_req_r.kind);
      check("source", src_of(k), conv_req_r.source);
      check("slot", s[3:0], slot_r);
      check("mode", i >= 5, normal_mode_r);
    end
  endtask

  task automatic t_cycle_fast();
    lat = 1;
    do_reset('{1'b1, 1'b1, GAIN_420, 6'sh00});
    run_seq(1'b1, 29);
  endtask

  task automatic t_no_safety_slow();
    do_reset('{1'b1, 1'b0, GAIN_420, 6'sh00});
    lat = 3;
    run_seq(1'b0, 17);
  endtask

  task automatic t_valid_low();
    logic [17:0] seen;
    seen = 18'h0;
    do_reset('{1'b0, 1'b1, GAIN_420, 6'sh00});
    lat = 2;
    repeat (20)
    begin
      @(negedge clk);
      seen = seen + 18'(conv_start);
    end
    check("idle starts", 18'h0, seen);
    @(posedge clk);
    #1 cfg.valid = 1'b1;
    run_seq(1'b1, 6);
  endtask

  task automatic t_offset_steps();
    // One step value per gain code 0 to C; -32 must read back as -31
    logic signed [5:0]  s [13] = '{6'sh1F, -6'sh20, -6'sh05, 6'sh07,
      6'sh01, -6'sh1F, 6'sh10, -6'sh01, 6'sh1F, -6'sh0A, 6'sh03,
      -6'sh1F, 6'sh1F};
    int                 u [13] = '{1250, 760, 1250, 760, 1250, 760, 1250,
      760, 520, 1250, 760, 520, 83};
    logic signed [5:0]  e;
    logic signed [17:0] sh;
    for (int i = 0; i < 13; i++)
    begin
      @(posedge clk);
      #1 cfg.gain_code = 4'(i);
      cfg.extended_offset_comp_steps = s[i];
      repeat (2) @(posedge clk);
      #1 e = (i == 1) ? -6'sh1F : s[i];
      sh = 18'(e * u[i]);
      check("steps", 18'(e), 18'(comp_steps_r));
      check("shift", sh, comp_shift_r);
    end
  endtask

  initial
  begin
    kinds = '{temp_autozero_conversion, temp_calibration_conversion,
      bridge_autozero_conversion, bridge_signal_conversion,
      bridge_signal_conversion, bridge_signal_conversion,
      temp_autozero_conversion, bridge_signal_conversion,
      temp_calibration_conversion, bridge_signal_conversion,
      common_mode_check_conversion, bridge_signal_conversion,
      positive_short_check, bridge_signal_conversion,
      negative_short_check, bridge_signal_conversion,
      bridge_autozero_conversion};
    num_errors = 0;
    n_compared = 0;
    lat = 1;
    rst_n = 1'b0;
    cfg = '0;
    t_cycle_fast();
    t_no_safety_slow();
    t_valid_low();
    t_offset_steps();
    tally_and_finish();
  end
endmodule
